// >>> core/bch_pkg.sv
// bch_pkg: offsets, reset values, field layout and carrier types of the bridge header window
package bch_pkg;

    // byte offsets of the registers in configuration space
    localparam logic [7:0] OFS_PREFETCH_RANGE_LIMIT = 8'h26;
    localparam logic [7:0] OFS_PREFETCH_BASE_HIGH_WORD = 8'h28;
    localparam logic [7:0] OFS_PREFETCH_LIMIT_HIGH_WORD = 8'h2C;
    localparam logic [7:0] OFS_IO_WINDOW_BASE_HIGH = 8'h30;
    localparam logic [7:0] OFS_IO_WINDOW_LIMIT_HIGH = 8'h32;
    localparam logic [7:0] OFS_CAPABILITY_LIST_HEAD = 8'h34;
    localparam logic [7:0] OFS_OPTION_ROM_BASE = 8'h38;
    localparam logic [7:0] OFS_IRQ_ROUTING_INFO = 8'h3C;
    localparam logic [7:0] OFS_IRQ_TERMINAL_SELECT = 8'h3D;

    // widths of the configuration port
    localparam int DWORD_IDX_W = 6;
    localparam int BYTE_LANES = 4;
    localparam int LANE_W = 8;
    localparam int DATA_W = 32;

    // reset and constant values
    localparam logic [15:0] PREFETCH_RANGE_LIMIT_RST = 16'h0000;
    localparam logic [15:0] IO_WINDOW_BASE_HIGH_RST = 16'h0000;
    localparam logic [15:0] IO_WINDOW_LIMIT_HIGH_RST = 16'h0000;
    localparam logic [7:0] IRQ_ROUTING_INFO_RST = 8'hFF;
    localparam logic [7:0] CAPABILITY_LIST_HEAD_VAL = 8'hDC;
    localparam logic [7:0] IRQ_TERMINAL_SELECT_VAL = 8'h00;
    localparam logic [31:0] READ_ZERO_WORD = 32'h0000_0000;

    // prefetch range limit field: bits 15:4 carry address bits 31:20
    localparam int PREF_FIELD_LSB = 4;
    localparam int PREF_FIELD_W = 12;
    localparam int ALIGN_BITS = 20;
    localparam logic [ALIGN_BITS-1:0] ALIGN_ZEROS = 20'h00000;
    localparam logic [ALIGN_BITS-1:0] ALIGN_ONES = 20'hFFFFF;
    localparam logic [PREF_FIELD_LSB-1:0] PREF_LOW_ZERO = 4'h0;

    // writable bits of each dword image, everything else is read-only
    localparam logic [31:0] WMASK_PREF_DWORD = 32'hFFF0_0000;
    localparam logic [31:0] WMASK_IO_DWORD = 32'hFFFF_FFFF;
    localparam logic [31:0] WMASK_IRQ_DWORD = 32'h0000_00FF;

    // one configuration access, dword addressed with byte enables
    typedef struct packed {
        logic rd;
        logic wr;
        logic [DWORD_IDX_W-1:0] dwordIdx;
        logic [BYTE_LANES-1:0] byteEn;
        logic [DATA_W-1:0] wdata;
    } bch_cfg_req_t;

    // the answer to one access
    typedef struct packed {
        logic ack;
        logic claimed;
        logic [DATA_W-1:0] rdata;
    } bch_cfg_rsp_t;

    // decoded window limits handed to forwarding logic
    typedef struct packed {
        logic [31:0] prefBaseAddr;
        logic [31:0] prefLimitAddr;
        logic prefHit;
        logic ioUpperHit;
    } bch_window_t;

endpackage : bch_pkg

// >>> core/bch_window_decode.sv
// bch_window_decode: expands the stored fields into full window addresses and checks a probe address
module bch_window_decode
    import bch_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [PREF_FIELD_W-1:0] prefBaseField,
    input wire logic [PREF_FIELD_W-1:0] prefLimitField,
    input wire logic [15:0] ioBaseHigh,
    input wire logic [15:0] ioLimitHigh,
    input wire logic [31:0] probeAddr,
    output bch_window_t window
);

    bch_window_t win_d;
    bch_window_t win_q;

    ////////////////////////////////////////////////////////////////////////////////
    // next values: base pads with zeros, limit pads with ones, so both land on 1M-byte steps
    always_comb begin
        win_d = win_q;
        win_d.prefBaseAddr = {prefBaseField, ALIGN_ZEROS}; // [R12]
        win_d.prefLimitAddr = {prefLimitField, ALIGN_ONES}; // [R2]
        // compare uses the padded forms so the last megabyte of the range still hits
        win_d.prefHit = (probeAddr >= {prefBaseField, ALIGN_ZEROS})
            && (probeAddr <= {prefLimitField, ALIGN_ONES}); // [R2] [R12]
        win_d.ioUpperHit = (probeAddr[31:16] >= ioBaseHigh) && (probeAddr[31:16] <= ioLimitHigh); // [R6] [R7]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered so every output of the top comes from a flop; costs one cycle of latency
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            win_q <= '0;
        end else begin
            win_q <= win_d;
        end
    end

    assign window = win_q;

endmodule : bch_window_decode

// >>> core/bch_header_window_regs.sv
// bch_header_window_regs: configuration header slice of the bridge, offsets 26h to 3Dh
//
// What this block does
// (R1) bits 15:4 of prefetch range limit are read/write, address bits 31:20
// (R2) prefetch limit compare fills low 20 address bits with ones
// (R3) bits 3:0 of prefetch range limit are read-only zero
// (R4) prefetch base high word is read-only zero, no 64-bit addressing
// (R5) prefetch limit high word is read-only zero, no 64-bit addressing
// (R6) I/O window base high is a full 16-bit read/write register
// (R7) I/O window limit high is a full 16-bit read/write register
// (R8) capability list head reads constant DCh, read-only
// (R9) option ROM base is read-only, always zero
// (R10) IRQ routing info is 8-bit read/write, resets to FFh, steers nothing
// (R11) IRQ terminal select reads zero in all eight bits
// (R12) prefetch base compare fills low 20 address bits with zeros
// (R13) writes to read-only bits and registers are ignored
module bch_header_window_regs
    import bch_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input bch_cfg_req_t cfgReq,
    output bch_cfg_rsp_t cfgRsp,
    input wire logic [PREF_FIELD_W-1:0] prefBaseField,
    input wire logic [31:0] probeAddr,
    output logic [PREF_FIELD_W-1:0] prefLimitField,
    output logic [15:0] ioBaseHigh,
    output logic [15:0] ioLimitHigh,
    output logic [7:0] irqRoutingInfo,
    output bch_window_t window
);

    ////////////////////////////////////////////////////////////////////////////////
    // dword indices of the registers, derived from the byte offsets
    localparam logic [DWORD_IDX_W-1:0] IDX_PREF_LIMIT = OFS_PREFETCH_RANGE_LIMIT[7:2];
    localparam logic [DWORD_IDX_W-1:0] IDX_PREF_BASE_HI = OFS_PREFETCH_BASE_HIGH_WORD[7:2];
    localparam logic [DWORD_IDX_W-1:0] IDX_PREF_LIMIT_HI = OFS_PREFETCH_LIMIT_HIGH_WORD[7:2];
    localparam logic [DWORD_IDX_W-1:0] IDX_IO_HIGH = OFS_IO_WINDOW_BASE_HIGH[7:2];
    localparam logic [DWORD_IDX_W-1:0] IDX_CAP_HEAD = OFS_CAPABILITY_LIST_HEAD[7:2];
    localparam logic [DWORD_IDX_W-1:0] IDX_ROM_BASE = OFS_OPTION_ROM_BASE[7:2];
    localparam logic [DWORD_IDX_W-1:0] IDX_IRQ = OFS_IRQ_ROUTING_INFO[7:2];

    // bit position of each register inside its dword
    localparam int POS_PREF_LIMIT = 8 * int'(OFS_PREFETCH_RANGE_LIMIT[1:0]);
    localparam int POS_IO_BASE = 8 * int'(OFS_IO_WINDOW_BASE_HIGH[1:0]);
    localparam int POS_IO_LIMIT = 8 * int'(OFS_IO_WINDOW_LIMIT_HIGH[1:0]);
    localparam int POS_CAP_HEAD = 8 * int'(OFS_CAPABILITY_LIST_HEAD[1:0]);
    localparam int POS_IRQ_INFO = 8 * int'(OFS_IRQ_ROUTING_INFO[1:0]);
    localparam int POS_IRQ_TERM = 8 * int'(OFS_IRQ_TERMINAL_SELECT[1:0]);

    ////////////////////////////////////////////////////////////////////////////////
    // storage
    logic [PREF_FIELD_W-1:0] prefLimit_q;
    logic [PREF_FIELD_W-1:0] prefLimit_d;
    logic [15:0] ioBase_q;
    logic [15:0] ioBase_d;
    logic [15:0] ioLimit_q;
    logic [15:0] ioLimit_d;
    logic [7:0] irqInfo_q;
    logic [7:0] irqInfo_d;

    // answer path
    bch_cfg_rsp_t rsp_q;
    bch_cfg_rsp_t rsp_d;

    // byte-enable expansion and dword images
    logic [DATA_W-1:0] laneMask;
    logic [DATA_W-1:0] imgPref;
    logic [DATA_W-1:0] imgIo;
    logic [DATA_W-1:0] imgIrq;
    logic [DATA_W-1:0] newPref;
    logic [DATA_W-1:0] newIo;
    logic [DATA_W-1:0] newIrq;
    logic [DATA_W-1:0] rdWord;
    logic inRange;

    ////////////////////////////////////////////////////////////////////////////////
    // one mask byte per enabled lane
    genvar lane;
    generate
        for (lane = 0; lane < BYTE_LANES; lane++) begin : g_lane
            assign laneMask[lane*LANE_W +: LANE_W] = {LANE_W{cfgReq.byteEn[lane]}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // dword images of the writable registers as seen on the bus
    always_comb begin
        imgPref = READ_ZERO_WORD;
        imgPref[POS_PREF_LIMIT +: 16] = {prefLimit_q, PREF_LOW_ZERO}; // [R3]
        imgIo = READ_ZERO_WORD;
        imgIo[POS_IO_BASE +: 16] = ioBase_q;
        imgIo[POS_IO_LIMIT +: 16] = ioLimit_q;
        imgIrq = READ_ZERO_WORD;
        imgIrq[POS_IRQ_INFO +: 8] = irqInfo_q;
        imgIrq[POS_IRQ_TERM +: 8] = IRQ_TERMINAL_SELECT_VAL; // [R11]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // merge write data only where lane enabled and bit writable; other bits keep their value
    always_comb begin
        newPref = (imgPref & ~(laneMask & WMASK_PREF_DWORD)) | (cfgReq.wdata & laneMask & WMASK_PREF_DWORD); // [R13]
        newIo = (imgIo & ~(laneMask & WMASK_IO_DWORD)) | (cfgReq.wdata & laneMask & WMASK_IO_DWORD); // [R13]
        newIrq = (imgIrq & ~(laneMask & WMASK_IRQ_DWORD)) | (cfgReq.wdata & laneMask & WMASK_IRQ_DWORD); // [R13]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next register values; dwords 28h, 2Ch, 34h and 38h have no storage, so writes vanish
    always_comb begin
        prefLimit_d = prefLimit_q;
        ioBase_d = ioBase_q;
        ioLimit_d = ioLimit_q;
        irqInfo_d = irqInfo_q;
        if (cfgReq.wr) begin
            case (cfgReq.dwordIdx)
                IDX_PREF_LIMIT: begin
                    prefLimit_d = newPref[POS_PREF_LIMIT + PREF_FIELD_LSB +: PREF_FIELD_W]; // [R1]
                end
                IDX_IO_HIGH: begin
                    ioBase_d = newIo[POS_IO_BASE +: 16]; // [R6]
                    ioLimit_d = newIo[POS_IO_LIMIT +: 16]; // [R7]
                end
                IDX_IRQ: begin
                    irqInfo_d = newIrq[POS_IRQ_INFO +: 8]; // [R10]
                end
                default: begin
                    // read-only or foreign dword: nothing stored [R13]
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register stage for the stored fields
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prefLimit_q <= PREFETCH_RANGE_LIMIT_RST[PREF_FIELD_LSB +: PREF_FIELD_W];
            ioBase_q <= IO_WINDOW_BASE_HIGH_RST;
            ioLimit_q <= IO_WINDOW_LIMIT_HIGH_RST;
            irqInfo_q <= IRQ_ROUTING_INFO_RST; // [R10]
        end else begin
            prefLimit_q <= prefLimit_d;
            ioBase_q <= ioBase_d;
            ioLimit_q <= ioLimit_d;
            irqInfo_q <= irqInfo_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read multiplexer; lanes that belong to other header registers read zero here
    always_comb begin
        inRange = 1'b1;
        case (cfgReq.dwordIdx)
            IDX_PREF_LIMIT: begin
                rdWord = imgPref; // [R1] [R3]
            end
            IDX_PREF_BASE_HI: begin
                rdWord = READ_ZERO_WORD; // [R4]
            end
            IDX_PREF_LIMIT_HI: begin
                rdWord = READ_ZERO_WORD; // [R5]
            end
            IDX_IO_HIGH: begin
                rdWord = imgIo; // [R6] [R7]
            end
            IDX_CAP_HEAD: begin
                rdWord = READ_ZERO_WORD;
                rdWord[POS_CAP_HEAD +: 8] = CAPABILITY_LIST_HEAD_VAL; // [R8]
            end
            IDX_ROM_BASE: begin
                rdWord = READ_ZERO_WORD; // [R9]
            end
            IDX_IRQ: begin
                rdWord = imgIrq; // [R10] [R11]
            end
            default: begin
                rdWord = READ_ZERO_WORD;
                inRange = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // answer one cycle after the access; disabled lanes read zero so partial reads stay clean
    always_comb begin
        rsp_d.ack = cfgReq.rd | cfgReq.wr;
        rsp_d.claimed = (cfgReq.rd | cfgReq.wr) & inRange;
        if (cfgReq.rd) begin
            rsp_d.rdata = rdWord & laneMask;
        end else begin
            rsp_d.rdata = READ_ZERO_WORD;
        end
    end

    // answer register; a read in the same cycle as a write returns the value before it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // window decode for the forwarding logic, fed straight from the stored fields and the prefBaseField input
    bch_window_decode u_window (
        .clock(clock),
        .rst_n(rst_n),
        .prefBaseField(prefBaseField),
        .prefLimitField(prefLimit_q),
        .ioBaseHigh(ioBase_q),
        .ioLimitHigh(ioLimit_q),
        .probeAddr(probeAddr),
        .window(window)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, each taken from a flop
    assign cfgRsp = rsp_q;
    assign prefLimitField = prefLimit_q;
    assign ioBaseHigh = ioBase_q;
    assign ioLimitHigh = ioLimit_q;
    assign irqRoutingInfo = irqInfo_q; // value only kept for software, no interrupt pin exists

endmodule : bch_header_window_regs

// >>> tb/bch_header_window_chk.sv
// bch_header_window_chk: port-level checks of the bridge header window slice
module bch_header_window_chk
    import bch_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input bch_cfg_req_t cfgReq,
    input bch_cfg_rsp_t cfgRsp,
    input wire logic [PREF_FIELD_W-1:0] prefBaseField,
    input wire logic [31:0] probeAddr,
    input wire logic [PREF_FIELD_W-1:0] prefLimitField,
    input wire logic [15:0] ioBaseHigh,
    input wire logic [15:0] ioLimitHigh,
    input wire logic [7:0] irqRoutingInfo,
    input bch_window_t window
);
    timeunit 1ns;
    timeprecision 100ps;
    // one clock domain, so clocking and reset are shared by every check
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // stored fields follow writes and nothing else
    pref_field_write_a: assert property (cfgReq.wr && cfgReq.dwordIdx == 6'h09 && cfgReq.byteEn[3:2] == 2'b11
        |=> prefLimitField == $past(cfgReq.wdata[31:20])) else $error("prefetch limit field not stored");
    pref_field_hold_a: assert property (!(cfgReq.wr && cfgReq.dwordIdx == 6'h09)
        |=> $stable(prefLimitField)) else $error("prefetch limit field changed without a write");
    io_pair_write_a: assert property (cfgReq.wr && cfgReq.dwordIdx == 6'h0C && cfgReq.byteEn == 4'hF
        |=> {ioLimitHigh, ioBaseHigh} == $past(cfgReq.wdata)) else $error("io window words not stored");
    irq_info_write_a: assert property (cfgReq.wr && cfgReq.dwordIdx == 6'h0F && cfgReq.byteEn[0]
        |=> irqRoutingInfo == $past(cfgReq.wdata[7:0])) else $error("irq routing byte not stored");
    irq_info_reset_a: assert property (!$past(rst_n) |-> irqRoutingInfo == IRQ_ROUTING_INFO_RST)
        else $error("irq routing byte reset value wrong");
    ////////////////////////////////////////////////////////////////////////////////
    // read-only places answer one cycle after the read with fixed values
    low_nibble_zero_a: assert property (cfgReq.rd && cfgReq.dwordIdx == 6'h09
        |=> cfgRsp.ack && cfgRsp.rdata[19:16] == 4'h0) else $error("limit low nibble not zero");
    ro_words_zero_a: assert property (cfgReq.rd && cfgReq.dwordIdx inside {6'h0A, 6'h0B, 6'h0E}
        |=> cfgRsp.ack && cfgRsp.rdata == READ_ZERO_WORD) else $error("read-only word not zero");
    cap_head_read_a: assert property (cfgReq.rd && cfgReq.dwordIdx == 6'h0D && cfgReq.byteEn[0]
        |=> cfgRsp.claimed && cfgRsp.rdata[7:0] == CAPABILITY_LIST_HEAD_VAL) else $error("capability head wrong");
    irq_pin_zero_a: assert property (cfgReq.rd && cfgReq.dwordIdx == 6'h0F
        |=> cfgRsp.ack && cfgRsp.rdata[15:8] == IRQ_TERMINAL_SELECT_VAL) else $error("irq terminal not zero");
    ////////////////////////////////////////////////////////////////////////////////
    // window addresses are the limit and base fields of the cycle before, padded to 1M-byte edges
    limit_pad_ones_a: assert property ($past(rst_n) |-> window.prefLimitAddr == {$past(prefLimitField), ALIGN_ONES})
        else $error("limit address padding wrong");
    base_pad_zeros_a: assert property ($past(rst_n) |-> window.prefBaseAddr == {$past(prefBaseField), ALIGN_ZEROS})
        else $error("base address padding wrong");
endmodule : bch_header_window_chk

bind bch_header_window_regs bch_header_window_chk chk_u (.clock(clock), .rst_n(rst_n), .cfgReq(cfgReq),
    .cfgRsp(cfgRsp), .prefBaseField(prefBaseField), .probeAddr(probeAddr), .prefLimitField(prefLimitField),
    .ioBaseHigh(ioBaseHigh), .ioLimitHigh(ioLimitHigh), .irqRoutingInfo(irqRoutingInfo), .window(window));

// >>> tb/bch_cfg_master.sv
// bch_cfg_master: configuration master model that issues one access at a time
module bch_cfg_master
    import bch_pkg::*;
(
    input wire logic clock,
    output bch_cfg_req_t cfgReq,
    input bch_cfg_rsp_t cfgRsp
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle bus until the first access
    initial cfgReq = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // drive at a falling edge, taken at the next rising edge; the answer stands one cycle only,
    // so it is taken at the following falling edge, before the strobe drops
    task automatic access(input logic rd, input logic wr, input logic [5:0] idx, input logic [3:0] be,
        input logic [31:0] wdata, output logic [31:0] rdata, output logic claimed);
        @(negedge clock);
        cfgReq = {rd, wr, idx, be, wdata};
        @(negedge clock);
        rdata = cfgRsp.rdata;
        claimed = cfgRsp.claimed;
        cfgReq = {2'b00, ~cfgReq[41:0]}; // released fields flip so a stale address cannot pass
    endtask : access
endmodule : bch_cfg_master

// >>> tb/test_bch_header_window_regs.sv
// test_bch_header_window_regs: directed register and window tests of the header slice
module test_bch_header_window_regs
    import bch_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    bch_cfg_req_t cfgReq;
    bch_cfg_rsp_t cfgRsp;
    logic [PREF_FIELD_W-1:0] prefBaseField = 12'h123;
    logic [31:0] probeAddr = 32'h0000_0000;
    bch_window_t window;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] rdVal;
    logic rdClaim;
    logic [31:0] rstTab [9:15] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_00DC, 32'h0, 32'h0000_00FF};
    logic [31:0] patTab [9:15] = '{32'hA5C0_0000, 32'h0, 32'h0, 32'hA5C3_5A3C, 32'h0000_00DC, 32'h0, 32'h0000_003C};
    logic [31:0] probeTab [5] = '{32'h1230_0000, 32'h122F_FFFF, 32'hA5CF_FFFF, 32'hA5D0_0000, 32'h5AEE_0000};
    logic [4:0] hitTab = 5'h15;
    logic [4:0] ioHitTab = 5'h10;
    ////////////////////////////////////////////////////////////////////////////////
    // clock and a hang guard well above the fewer than a hundred cycles the tests need
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            complete_run();
        end
    end
    bch_cfg_master master_u (.clock(clock), .cfgReq(cfgReq), .cfgRsp(cfgRsp));
    bch_header_window_regs dut_u (.clock(clock), .rst_n(rst_n), .cfgReq(cfgReq), .cfgRsp(cfgRsp),
        .prefBaseField(prefBaseField), .probeAddr(probeAddr), .prefLimitField(), .ioBaseHigh(),
        .ioLimitHigh(), .irqRoutingInfo(), .window(window));
    ////////////////////////////////////////////////////////////////////////////////
    // comparison, access wrappers and the single exit
    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : compare
    task automatic wr_reg(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] data);
        master_u.access(1'b0, 1'b1, idx, be, data, rdVal, rdClaim);
    endtask : wr_reg
    task automatic rd_chk(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] exp);
        master_u.access(1'b1, 1'b0, idx, be, 32'h0000_0000, rdVal, rdClaim);
        compare($sformatf("dword %h", idx), exp, rdVal);
    endtask : rd_chk
    task automatic complete_run();
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    // reset values, pattern write to every dword, lane write, window probes, second reset
    initial begin
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        for (int i = 9; i < 16; i++) begin
            rd_chk(6'(i), 4'hF, rstTab[i]);
        end
        for (int i = 9; i < 16; i++) begin
            wr_reg(6'(i), 4'hF, 32'hA5C3_5A3C);
        end
        for (int i = 9; i < 16; i++) begin
            rd_chk(6'(i), 4'hF, patTab[i]);
        end
        wr_reg(6'h0C, 4'h1, 32'h0000_00EE);
        rd_chk(6'h0C, 4'hF, 32'hA5C3_5AEE);
        rd_chk(6'h10, 4'hF, 32'h0000_0000);
        compare("claimed", 32'h0, {31'h0, rdClaim});
        for (int i = 0; i < 5; i++) begin
            @(negedge clock);
            probeAddr = probeTab[i];
            @(negedge clock);
            compare("prefHit", {31'h0, hitTab[i]}, {31'h0, window.prefHit});
            compare("ioUpperHit", {31'h0, ioHitTab[i]}, {31'h0, window.ioUpperHit});
        end
        compare("prefLimitAddr", 32'hA5CF_FFFF, window.prefLimitAddr);
        compare("prefBaseAddr", 32'h1230_0000, window.prefBaseAddr);
        // moving the base above the probe must turn the hit off
        @(negedge clock);
        prefBaseField = 12'hA5D;
        @(negedge clock);
        compare("prefBaseAddr", 32'hA5D0_0000, window.prefBaseAddr);
        compare("prefHit", 32'h0, {31'h0, window.prefHit});
        @(negedge clock);
        rst_n = 1'b0;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        rd_chk(6'h0F, 4'hF, 32'h0000_00FF);
        rd_chk(6'h0C, 4'hF, 32'h0000_0000);
        complete_run();
    end
endmodule : test_bch_header_window_regs
